// File: logic/adc_cfg_consts.vh
`ifndef ADC_CFG_CONSTS_VH
`define ADC_CFG_CONSTS_VH
// word layout
`define WORD_BITS 24
`define ADDR_BITS 8
`define DATA_BITS 16
`define BIT_CNT_W 5
`define BIT_CNT_LAST 5'd23
// register offsets
`define OFS_SOFT_RESET 8'h00
`define OFS_POWER_DOWN 8'h0f
`define OFS_DRIVE_CURRENT 8'h11
`define OFS_TERMINATION 8'h12
`define OFS_POLARITY_SWAP 8'h24
`define OFS_TEST_PATTERN 8'h25
`define OFS_CUSTOM_A 8'h26
`define OFS_CUSTOM_B 8'h27
`define OFS_GAIN_LOW 8'h2a
`define OFS_GAIN_HIGH 8'h2b
`define OFS_CLOCK_PHASE 8'h42
`define OFS_TRAINING 8'h45
// field positions
`define FLD_SOFT_RESET 0
`define FLD_DEEP_SLEEP 8
`define FLD_FULL_PD 9
`define FLD_PIN_MODE_LO 10
`define FLD_PIN_MODE_HI 11
`define FLD_TERM_EN 14
// reset values
`define RST_ZERO 16'h0000
`define RST_DRIVE 16'h0000
`define RST_PHASE 16'h0040
// timing
`define CLK_PERIOD_NS 40
`define PULSE_MIN_NS 20
`define PULSE_MIN_CYC ((`PULSE_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

// File: logic/adc_serial_config_regs.v
`timescale 1ns/1ps
`include "adc_cfg_consts.vh"

module adc_serial_config_regs (
  input wire clk_in,
  input wire rst_n_in,
  input wire clk_en_in,
  input wire select_n_in,
  input wire serial_clk_in,
  input wire serial_in_line_in,
  input wire async_reset_n_in,
  input wire powerdown_pin_in,
  output reg [7:0] channel_light_sleep_out,
  output reg channel_deep_sleep_out,
  output reg full_powerdown_out,
  output reg output_clocks_run_out,
  output reg [1:0] powerdown_pin_mode_out,
  output reg [15:0] drive_current_out,
  output reg [15:0] termination_out,
  output reg [7:0] input_polarity_swap_out,
  output reg [2:0] test_pattern_out,
  output reg [13:0] custom_code_a_out,
  output reg [13:0] custom_code_b_out,
  output reg [15:0] gain_channels_low_out,
  output reg [15:0] gain_channels_high_out,
  output reg [1:0] bit_clock_phase_out,
  output reg [1:0] link_training_out,
  output reg powerdown_pulse_out
);

  // ****************************************
  // pin synchronisers
  // ****************************************
  // three stages; stage 1 only feeds stage 2, a change counts when 2 and 3 agree
  // stage 1 may go metastable, so nothing but stage 2 ever looks at it
  // stable_r holds the last value on which stages 2 and 3 agreed
  // a one-cycle glitch that reaches stage 2 only never gets into stable_r
  // cost: every pin is seen three to four system clocks late
  // all pins share the same latency, so data and clock keep their order
  // reset value matches each pin's idle level: select high, clock low,
  // reset pin high, power-down pin low; no false edge follows reset
  // the data bit resets high, which is harmless outside a frame
  reg [4:0] sync1_r;
  reg [4:0] sync2_r;
  reg [4:0] sync3_r;
  reg [4:0] stable_r;
  wire [4:0] pins_raw;
  assign pins_raw = {powerdown_pin_in, async_reset_n_in, serial_in_line_in, serial_clk_in, select_n_in};

  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sync1_r <= 5'h0d;
      sync2_r <= 5'h0d;
      sync3_r <= 5'h0d;
      stable_r <= 5'h0d;
    end else if (clk_en_in) begin
      sync1_r <= pins_raw;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
      stable_r <= (sync2_r & sync3_r) | (~(sync2_r ^ sync3_r) & sync3_r) | ((sync2_r ^ sync3_r) & stable_r);
    end
  end

  wire sel_n_s;
  wire sclk_s;
  wire serial_in_line_s;
  wire pin_rst_n_s;
  wire pd_pin_s;
  assign sel_n_s = stable_r[0];
  assign sclk_s = stable_r[1];
  assign serial_in_line_s = stable_r[2];
  assign pin_rst_n_s = stable_r[3];
  assign pd_pin_s = stable_r[4];

  // ****************************************
  // edge detection and pulse width checks
  // ****************************************
  reg sclk_prev_r;
  reg sel_prev_r;
  reg [3:0] rst_low_cnt_r;
  reg [3:0] pd_high_cnt_r;
  wire sclk_rise;
  wire sel_fall;
  wire pin_reset;
  wire pd_cycle;
  assign sclk_rise = sclk_s & ~sclk_prev_r;
  assign sel_fall = sel_prev_r & ~sel_n_s;
  // a short pulse may be lost at this clock rate; 20 ns is under one period
  // the minimum pulse is rounded up to whole system clocks
  // pin reset acts on every synced low cycle once the minimum is met
  // power-down pin pulse fires once, in the first qualifying cycle
  // counters saturate so a pin held for hours never wraps
  // serial clock edges are found on the synced copy, never on the raw pin
  // select fall restarts the bit counter for a new frame
  // limitation: serial clock must stay high and low for two system
  // clocks each, or edges merge in the synchroniser and bits are lost
  assign pin_reset = ~pin_rst_n_s && (rst_low_cnt_r >= `PULSE_MIN_CYC - 1);
  assign pd_cycle = pd_pin_s && (pd_high_cnt_r == `PULSE_MIN_CYC - 1);

  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sclk_prev_r <= 1'b0;
      sel_prev_r <= 1'b1;
      rst_low_cnt_r <= 4'h0;
      pd_high_cnt_r <= 4'h0;
    end else if (clk_en_in) begin
      sclk_prev_r <= sclk_s;
      sel_prev_r <= sel_n_s;
      if (pin_rst_n_s)
        rst_low_cnt_r <= 4'h0;
      else if (rst_low_cnt_r != 4'hf)
        rst_low_cnt_r <= rst_low_cnt_r + 4'h1;
      if (!pd_pin_s)
        pd_high_cnt_r <= 4'h0;
      else if (pd_high_cnt_r != 4'hf)
        pd_high_cnt_r <= pd_high_cnt_r + 4'h1;
    end
  end

  // ****************************************
  // serial shifter
  // ****************************************
  reg [22:0] shift_r;
  reg [4:0] bit_cnt_r;
  reg word_done_r;
  wire [23:0] word_full;
  wire commit;
  assign word_full = {shift_r, serial_in_line_s};
  // keep only the first word of a select period; surplus edges are ignored
  // the current bit joins the shift register through word_full, so the
  // commit sees all 24 bits in the same cycle as the 24th edge
  // word_done_r blocks further shifting until select goes high again
  // trade-off: a host that wants several writes must toggle select per word
  // bits arrive msb first: address first, then data
  // the shift register is not cleared on select; the bit counter is,
  // so stale bits are pushed out before the next commit
  // a pin reset also restarts the frame so no half word survives it
  assign commit = ~sel_n_s && sclk_rise && !word_done_r && (bit_cnt_r == `BIT_CNT_LAST);

  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      shift_r <= 23'h000000;
      bit_cnt_r <= 5'h00;
      word_done_r <= 1'b0;
    end else if (clk_en_in) begin
      if (pin_reset || sel_n_s || sel_fall) begin
        bit_cnt_r <= 5'h00;
        word_done_r <= 1'b0;
      end else if (sclk_rise && !word_done_r) begin
        shift_r <= word_full[22:0];
        if (bit_cnt_r == `BIT_CNT_LAST) begin
          bit_cnt_r <= 5'h00;
          word_done_r <= 1'b1;
        end else begin
          bit_cnt_r <= bit_cnt_r + 5'h01;
        end
      end
    end
  end

  wire [7:0] wr_addr;
  wire [15:0] wr_data;
  assign wr_addr = word_full[23:16];
  assign wr_data = word_full[15:0];
  // software reset is a strobe, not a stored bit: it acts in the commit
  // cycle and is gone the next, which makes it clear itself
  // writing zero to bit 0 does nothing at all
  // the strobe and a pin reset share the same default-load path
  // no other field lives in this register, so nothing else is kept
  // a write to an unmapped address is dropped silently
  wire soft_reset;
  assign soft_reset = commit && (wr_addr == `OFS_SOFT_RESET) && wr_data[`FLD_SOFT_RESET];

  // ****************************************
  // configuration registers
  // ****************************************
  reg [15:0] pd_reg_r;
  reg [15:0] drive_r;
  reg [15:0] term_r;
  reg [7:0] pol_r;
  reg [2:0] pat_r;
  reg [13:0] code_a_r;
  reg [13:0] code_b_r;
  reg [15:0] gain_lo_r;
  reg [15:0] gain_hi_r;
  reg [1:0] phase_r;
  reg [1:0] train_r;

  // write-only: no read-back path exists
  // each register stores only its documented fields; spare bits read as
  // zero at the outputs so nothing downstream sees stray values
  // reset and default-load use the same constants, so they cannot drift
  // a reset event wins over a commit in the same cycle
  // drive current resets to the code for the nominal drive
  // phase resets to the 90 degree setting
  // test pattern bits are stored as written; the host picks one at a time
  // custom codes keep d15:d2, the lsb sits at d2
  // gain nibbles are stored whole, channel order left to the consumer
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pd_reg_r <= `RST_ZERO;
      drive_r <= `RST_DRIVE;
      term_r <= `RST_ZERO;
      pol_r <= 8'h00;
      pat_r <= 3'h0;
      code_a_r <= 14'h0000;
      code_b_r <= 14'h0000;
      gain_lo_r <= `RST_ZERO;
      gain_hi_r <= `RST_ZERO;
      phase_r <= 2'h2;
      train_r <= 2'h0;
    end else if (clk_en_in) begin
      if (pin_reset || soft_reset) begin
        pd_reg_r <= `RST_ZERO;
        drive_r <= `RST_DRIVE;
        term_r <= `RST_ZERO;
        pol_r <= 8'h00;
        pat_r <= 3'h0;
        code_a_r <= 14'h0000;
        code_b_r <= 14'h0000;
        gain_lo_r <= `RST_ZERO;
        gain_hi_r <= `RST_ZERO;
        phase_r <= 2'h2;
        train_r <= 2'h0;
      end else if (commit) begin
        case (wr_addr)
          `OFS_POWER_DOWN: pd_reg_r <= {4'h0, wr_data[11:0]};
          `OFS_DRIVE_CURRENT: drive_r <= {5'h00, wr_data[10:8], 1'b0, wr_data[6:4], 1'b0, wr_data[2:0]};
          `OFS_TERMINATION: term_r <= {1'b0, wr_data[14], 3'h0, wr_data[10:8], 1'b0, wr_data[6:4], 1'b0,
                                       wr_data[2:0]};
          `OFS_POLARITY_SWAP: pol_r <= wr_data[7:0];
          `OFS_TEST_PATTERN: pat_r <= wr_data[6:4];
          `OFS_CUSTOM_A: code_a_r <= wr_data[15:2];
          `OFS_CUSTOM_B: code_b_r <= wr_data[15:2];
          `OFS_GAIN_LOW: gain_lo_r <= wr_data;
          `OFS_GAIN_HIGH: gain_hi_r <= wr_data;
          `OFS_CLOCK_PHASE: phase_r <= wr_data[6:5];
          `OFS_TRAINING: train_r <= wr_data[1:0];
          default: pd_reg_r <= pd_reg_r;
        endcase
      end
    end
  end

  // ****************************************
  // power state decode
  // ****************************************
  // pin mode: x1 light sleep all, 10 deep sleep, 00 full power-down
  // the pin acts as a level; it never writes the register bits
  // register and pin requests are or-ed, so either can power down
  // pin light sleep forces every channel; channels cannot be picked by pin
  // deep sleep keeps output clocks running for the receiver
  // only full power-down stops the output clocks
  // the decode is pure logic; the outputs below register it
  reg pin_light;
  reg pin_deep;
  reg pin_full;
  always @* begin
    pin_light = pd_pin_s && pd_reg_r[`FLD_PIN_MODE_LO];
    pin_deep = pd_pin_s && (pd_reg_r[`FLD_PIN_MODE_HI:`FLD_PIN_MODE_LO] == 2'b10);
    pin_full = pd_pin_s && (pd_reg_r[`FLD_PIN_MODE_HI:`FLD_PIN_MODE_LO] == 2'b00);
  end

  // ****************************************
  // registered outputs
  // ****************************************
  // every output comes straight from a flip-flop, one clock after the
  // register or pin change, so consumers see no decode glitches
  // the clock enable freezes these together with the rest of the state
  // reset values equal the register defaults
  // the power-down pulse flags the first synced cycle of a pin cycle in
  // full power-down mode; it is a marker, not a level
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      channel_light_sleep_out <= 8'h00;
      channel_deep_sleep_out <= 1'b0;
      full_powerdown_out <= 1'b0;
      output_clocks_run_out <= 1'b1;
      powerdown_pin_mode_out <= 2'h0;
      drive_current_out <= `RST_DRIVE;
      termination_out <= `RST_ZERO;
      input_polarity_swap_out <= 8'h00;
      test_pattern_out <= 3'h0;
      custom_code_a_out <= 14'h0000;
      custom_code_b_out <= 14'h0000;
      gain_channels_low_out <= `RST_ZERO;
      gain_channels_high_out <= `RST_ZERO;
      bit_clock_phase_out <= 2'h2;
      link_training_out <= 2'h0;
      powerdown_pulse_out <= 1'b0;
    end else if (clk_en_in) begin
      channel_light_sleep_out <= pin_light ? 8'hff : pd_reg_r[7:0];
      channel_deep_sleep_out <= pd_reg_r[`FLD_DEEP_SLEEP] | pin_deep;
      full_powerdown_out <= pd_reg_r[`FLD_FULL_PD] | pin_full;
      // clocks only stop in full power-down; sleep modes keep receiver lock
      // a receiver that loses these clocks must retrain after wake-up
      // deep sleep saves more power than all-channel light sleep but
      // wakes as slowly as full power-down
      // clocks run again one cycle after the power-down request ends
      output_clocks_run_out <= ~(pd_reg_r[`FLD_FULL_PD] | pin_full);
      powerdown_pin_mode_out <= pd_reg_r[`FLD_PIN_MODE_HI:`FLD_PIN_MODE_LO];
      drive_current_out <= drive_r;
      termination_out <= term_r;
      input_polarity_swap_out <= pol_r;
      test_pattern_out <= pat_r;
      custom_code_a_out <= code_a_r;
      custom_code_b_out <= code_b_r;
      gain_channels_low_out <= gain_lo_r;
      gain_channels_high_out <= gain_hi_r;
      bit_clock_phase_out <= phase_r;
      link_training_out <= train_r;
      powerdown_pulse_out <= pd_cycle && pd_reg_r[`FLD_PIN_MODE_HI:`FLD_PIN_MODE_LO] == 2'b00;
    end
  end

endmodule // adc_serial_config_regs

// File: verif/adc_cfg_checker_sva.sv
`timescale 1ns/1ps
module adc_cfg_checker (
  input wire clk_in,
  input wire rst_n_in,
  input wire select_n_in,
  input wire async_reset_n_in,
  input wire powerdown_pin_in,
  input wire [7:0] channel_light_sleep_out,
  input wire channel_deep_sleep_out,
  input wire full_powerdown_out,
  input wire output_clocks_run_out,
  input wire [1:0] powerdown_pin_mode_out,
  input wire [15:0] drive_current_out,
  input wire [15:0] termination_out,
  input wire [1:0] bit_clock_phase_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  // ****
  // port rules
  // ****
  a_reset_defaults: assert property ($rose(rst_n_in) |-> drive_current_out == 16'h0000 && bit_clock_phase_out == 2'b10)
    else $error("defaults missing after reset");
  // a long idle select must leave drive, termination, pin mode and phase alone
  a_idle_quiet: assert property ((select_n_in && async_reset_n_in)[*8] |=>
    $stable({drive_current_out, termination_out, powerdown_pin_mode_out, bit_clock_phase_out}))
    else $error("setting changed while idle");
  a_deep_clocks: assert property (channel_deep_sleep_out && !full_powerdown_out |-> output_clocks_run_out)
    else $error("clocks stopped in deep sleep");
  a_term_mask: assert property ((termination_out & 16'hb888) == 16'h0000)
    else $error("termination spare bit set");
  a_drive_mask: assert property ((drive_current_out & 16'hf888) == 16'h0000)
    else $error("drive spare bit set");
  a_pin_light: assert property ((powerdown_pin_in && powerdown_pin_mode_out[0])[*6] |-> channel_light_sleep_out == 8'hff)
    else $error("pin light sleep missing");
  a_pin_deep: assert property ((powerdown_pin_in && powerdown_pin_mode_out == 2'b10)[*6] |-> channel_deep_sleep_out)
    else $error("pin deep sleep missing");
  a_pin_full: assert property ((powerdown_pin_in && powerdown_pin_mode_out == 2'b00)[*6] |-> full_powerdown_out)
    else $error("pin power-down missing");
  c_deep: cover property (channel_deep_sleep_out);
  c_full: cover property (full_powerdown_out);
  c_pin_reset: cover property ($fell(async_reset_n_in));
endmodule // adc_cfg_checker

bind adc_serial_config_regs adc_cfg_checker u_chk (.clk_in(clk_in), .rst_n_in(rst_n_in), .select_n_in(select_n_in),
  .async_reset_n_in(async_reset_n_in), .powerdown_pin_in(powerdown_pin_in),
  .channel_light_sleep_out(channel_light_sleep_out), .channel_deep_sleep_out(channel_deep_sleep_out),
  .full_powerdown_out(full_powerdown_out), .output_clocks_run_out(output_clocks_run_out),
  .powerdown_pin_mode_out(powerdown_pin_mode_out), .drive_current_out(drive_current_out),
  .termination_out(termination_out), .bit_clock_phase_out(bit_clock_phase_out));

// File: verif/host_model.sv
`timescale 1ns/1ps
module host_model (
  input wire clk_in,
  output logic select_n_out,
  output logic serial_clk_out,
  output logic data_out
);
  logic busy = 1'b0;
  initial begin
    select_n_out = 1'b1;
    serial_clk_out = 1'b0;
    data_out = 1'b0;
  end
  // released data line toggles, so a stale bit never looks valid
  always @(negedge clk_in) if (!busy) data_out <= ~data_out;
  // one select period of n bits, msb first; serial clock 320 ns, idle low
  task automatic send(input logic [47:0] bits, input int n);
    busy = 1'b1;
    select_n_out = 1'b0;
    repeat (4) @(negedge clk_in);
    for (int i = 47; i > 47 - n; i--) begin
      data_out = bits[i];
      repeat (4) @(negedge clk_in);
      serial_clk_out = 1'b1;
      repeat (4) @(negedge clk_in);
      serial_clk_out = 1'b0;
    end
    repeat (4) @(negedge clk_in);
    select_n_out = 1'b1;
    busy = 1'b0;
    repeat (8) @(negedge clk_in);
  endtask
endmodule // host_model

// File: verif/test_adc_serial_config_regs.sv
`timescale 1ns/1ps
module test_adc_serial_config_regs;
  logic clk_in, rst_n_in, select_n_in, serial_clk_in, serial_in_line_in, async_reset_n_in, powerdown_pin_in;
  logic channel_deep_sleep_out, full_powerdown_out, output_clocks_run_out, powerdown_pulse_out;
  logic [1:0] powerdown_pin_mode_out, bit_clock_phase_out, link_training_out;
  logic [2:0] test_pattern_out;
  logic [7:0] channel_light_sleep_out, input_polarity_swap_out;
  logic [13:0] custom_code_a_out, custom_code_b_out;
  logic [15:0] drive_current_out, termination_out, gain_channels_low_out, gain_channels_high_out;
  logic [15:0] shadow [0:255];
  logic [7:0] addrs [11] = '{8'h0f, 8'h11, 8'h12, 8'h24, 8'h25, 8'h26, 8'h27, 8'h2a, 8'h2b, 8'h42, 8'h45};
  typedef struct {logic [7:0] a; logic [15:0] v;} note_t;
  note_t q[$];
  event ev;
  int n_mismatch = 0;
  int check_count = 0;
  host_model host (.clk_in, .select_n_out(select_n_in), .serial_clk_out(serial_clk_in), .data_out(serial_in_line_in));
  adc_serial_config_regs DUT (.clk_in, .rst_n_in, .clk_en_in(1'b1), .select_n_in, .serial_clk_in,
    .serial_in_line_in, .async_reset_n_in, .powerdown_pin_in, .channel_light_sleep_out, .channel_deep_sleep_out,
    .full_powerdown_out, .output_clocks_run_out, .powerdown_pin_mode_out, .drive_current_out, .termination_out,
    .input_polarity_swap_out, .test_pattern_out, .custom_code_a_out, .custom_code_b_out, .gain_channels_low_out,
    .gain_channels_high_out, .bit_clock_phase_out, .link_training_out, .powerdown_pulse_out);
  initial begin
    clk_in = 1'b0;
    forever #20 clk_in = ~clk_in;
  end
  // ****
  // expectation helpers
  // ****
  function automatic logic [15:0] msk(input logic [7:0] a);
    case (a)
      8'h0f: return 16'h0fff;
      8'h11: return 16'h0777;
      8'h12: return 16'h4777;
      8'h24: return 16'h00ff;
      8'h25: return 16'h0070;
      8'h26, 8'h27: return 16'hfffc;
      8'h2a, 8'h2b: return 16'hffff;
      8'h42: return 16'h0060;
      8'h45: return 16'h0003;
      default: return 16'h0000;
    endcase
  endfunction
  // outputs folded back into register layout; 8'hff is the sleep status
  function automatic logic [15:0] obs(input logic [7:0] a);
    case (a)
      8'h0f: return {4'h0, powerdown_pin_mode_out, full_powerdown_out, channel_deep_sleep_out, channel_light_sleep_out};
      8'h11: return drive_current_out;
      8'h12: return termination_out;
      8'h24: return {8'h00, input_polarity_swap_out};
      8'h25: return {9'h000, test_pattern_out, 4'h0};
      8'h26: return {custom_code_a_out, 2'b00};
      8'h27: return {custom_code_b_out, 2'b00};
      8'h2a: return gain_channels_low_out;
      8'h2b: return gain_channels_high_out;
      8'h42: return {9'h000, bit_clock_phase_out, 5'h00};
      8'h45: return {14'h0000, link_training_out};
      default: return {4'h0, powerdown_pulse_out, output_clocks_run_out, full_powerdown_out, channel_deep_sleep_out,
        channel_light_sleep_out};
    endcase
  endfunction
  task automatic dflt();
    foreach (shadow[i]) shadow[i] = (i == 8'h42) ? 16'h0040 : 16'h0000;
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    host.send({a, d, 24'h000000}, 24);
    if (msk(a) != 16'h0000) shadow[a] = d & msk(a);
    if (a == 8'h00 && d[0]) dflt();
  endtask
  task automatic chk(input logic [7:0] a, input logic [15:0] e);
    q.push_back('{a, e});
    -> ev;
    @(negedge clk_in);
  endtask
  task automatic chk_all();
    repeat (4) @(negedge clk_in);
    foreach (addrs[i]) chk(addrs[i], shadow[addrs[i]]);
  endtask
  // watcher takes the oldest note as each result appears
  always @(ev) begin
    note_t n;
    n = q.pop_front();
    check_count++;
    if (obs(n.a) !== n.v) begin
      n_mismatch++;
      $display("mismatch t=%0t addr %h got %h exp %h", $time, n.a, obs(n.a), n.v);
    end
  end
  task automatic results();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // about 23 words of 8.3 us each; generous margin
  initial begin
    #3000000;
    n_mismatch++;
    results();
  end
  // ****
  // tests
  // ****
  initial begin
    void'($urandom(33));
    rst_n_in = 1'b0;
    async_reset_n_in = 1'b1;
    powerdown_pin_in = 1'b0;
    dflt();
    repeat (8) @(negedge clk_in);
    rst_n_in = 1'b1;
    // start-up power-down cycle before relying on the part
    powerdown_pin_in = 1'b1;
    repeat (2) @(negedge clk_in);
    powerdown_pin_in = 1'b0;
    repeat (8) @(negedge clk_in);
    chk_all();
    $display("test defaults done");
    foreach (addrs[i]) wr(addrs[i], 16'($urandom));
    chk_all();
    $display("test random writes done");
    host.send({8'h24, 16'h00a5, 8'h11, 16'h0000}, 48);
    shadow[8'h24] = 16'h00a5;
    wr(8'h33, 16'hffff);
    chk_all();
    $display("test surplus bits done");
    // every pin mode; first look in the cycle the pulse marker stands
    for (int m = 0; m < 4; m++) begin
      wr(8'h0f, 16'(m) << 10);
      powerdown_pin_in = 1'b1;
      repeat (5) @(negedge clk_in);
      chk(8'hff, m[0] ? 16'h04ff : (m[1] ? 16'h0500 : 16'h0a00));
      repeat (2) @(negedge clk_in);
      chk(8'hff, m[0] ? 16'h04ff : (m[1] ? 16'h0500 : 16'h0200));
      powerdown_pin_in = 1'b0;
      repeat (8) @(negedge clk_in);
    end
    wr(8'h0f, 16'h0200);
    chk(8'h0f, 16'h0200);
    wr(8'h0f, 16'h0000);
    chk(8'h0f, 16'h0000);
    $display("test power-down done");
    wr(8'h00, 16'h0001);
    chk_all();
    wr(8'h42, 16'h0020);
    chk(8'h42, 16'h0020);
    $display("test soft reset done");
    wr(8'h12, 16'h4777);
    async_reset_n_in = 1'b0;
    repeat (3) @(negedge clk_in);
    async_reset_n_in = 1'b1;
    dflt();
    chk_all();
    $display("test pin reset done");
    results();
  end
endmodule // test_adc_serial_config_regs
